/* File: design/ptcc_defines.svh */
// Constants for the periodic timer capture and single pulse block.
`ifndef PTCC_DEFINES_SVH
`define PTCC_DEFINES_SVH
`define PTCC_CNT_W        10
`define PTCC_CNT_MAX      10'h3FF
`define PTCC_CNT_ZERO     10'h000
`define PTCC_MODE_CMP     2'h0
`define PTCC_MODE_CAPT    2'h1
`define PTCC_MODE_PWM     2'h2
`define PTCC_MODE_TMR     2'h3
`define PTCC_IO_RISE      2'h0
`define PTCC_IO_FALL      2'h1
`define PTCC_IO_BOTH      2'h2
`define PTCC_IO_NONE      2'h3
`define PTCC_OFF_CTRL     8'h00
`define PTCC_OFF_COMPARE_A_VALUE     8'h04
`define PTCC_OFF_PERIOD_COMPARE_VALUE     8'h08
`define PTCC_OFF_CNT      8'h0C
`define PTCC_OFF_STAT     8'h10
`define PTCC_OFF_MASK     8'h14
`define PTCC_BIT_RUN      0
`define PTCC_BIT_SRC      1
`define PTCC_BIT_IO       2
`define PTCC_BIT_MODE     4
`define PTCC_BIT_CLR      6
`define PTCC_BIT_OC       7
`define PTCC_BIT_POL      8
`define PTCC_CTRL_W       9
`define PTCC_IRQ_A        0
`define PTCC_IRQ_P        1
`define PTCC_IRQ_W        2
`define PTCC_HTRANS_NONSEQ 2'h2
`define PTCC_HSIZE_WORD   3'h2
`endif

/* File: design/ptcc_pkg.sv */
// Types for the periodic timer capture and single pulse block.
package ptcc_pkg;
    typedef struct packed {
        logic       output_polarity;
        logic       output_initial_level;
        logic       clear_select;
        logic [1:0] mode_select;
        logic [1:0] io_function;
        logic       capture_source_select;
        logic       counter_run;
    } ptcc_ctrl_t;

    typedef struct packed {
        logic       capture_input_pin;
        logic       clock_trigger_pin;
    } ptcc_pins_t;
endpackage

/* File: design/ptcc_timer.sv */
// Periodic timer capture input and single pulse logic with an AHB-Lite register slave.
//
// Behaviour
// [RQ1] Mode select value 01 puts the timer into capture operation.
// [RQ2] Capture source is the capture pin or the trigger pin, per select bit.
// [RQ3] Io function picks rising, falling or both edges as capture event.
// [RQ4] Counter starts counting on a low to high change of the run bit.
// [RQ5] Active capture edge copies counter into compare A and raises interrupt.
// [RQ6] Captures never stop or clear the counter; only run falling stops it.
// [RQ7] Period match in capture operation wraps counter to zero and raises interrupt.
// [RQ8] Period value zero lets the counter run its full range before wrapping.
// [RQ9] Io function 11 in capture operation blocks captures; counter still runs.
// [RQ10] Clear select, initial level and polarity bits do nothing in capture.
// [RQ11] Single pulse starts on run bit set or trigger pin active edge.
// [RQ12] Trigger pin active edge sets the run bit in single pulse operation.
// [RQ13] Software keeps io function at 11 throughout single pulse operation.
// [RQ14] Compare A match in single pulse clears run bit and raises interrupt.
// [RQ15] Counter is ten bits and overflows from all ones to zero.
// [RQ16] Capture and trigger pins are synchronised before edge detection.
// [RQ17] Interrupt flags stay set until software clears them.
`timescale 1ns/10ps
`include "ptcc_defines.svh"

module ptcc_timer #(
    parameter int CNT_W = `PTCC_CNT_W
) (
    input  wire logic              hclk,          // Timer and bus clock.
    input  wire logic              hresetn,       // Asynchronous reset, active low.
    input  wire logic              hsel,          // Slave select.
    input  wire logic [31:0]       haddr,         // Byte address.
    input  wire logic [1:0]        htrans,        // Transfer type.
    input  wire logic              hwrite,        // Write when high.
    input  wire logic [2:0]        hsize,         // Transfer size.
    input  wire logic              hready,        // Bus ready in.
    input  wire logic [31:0]       hwdata,        // Write data.
    output logic      [31:0]       hrdata,        // Read data.
    output logic                   hreadyout,     // Slave ready.
    output logic                   hresp,         // Always OKAY.
    input  wire ptcc_pkg::ptcc_pins_t pins,       // Capture and trigger pins.
    output logic                   pulse_out,     // Single pulse output level.
    output logic                   irq            // Level interrupt.
);

    // Control, compare and counter state.
    ptcc_pkg::ptcc_ctrl_t   ctrl_q;
    logic [CNT_W-1:0]       cnt_q;
    logic [CNT_W-1:0]       compare_a_value_q;
    logic [CNT_W-1:0]       period_compare_value_q;
    logic [`PTCC_IRQ_W-1:0] stat_q;
    logic [`PTCC_IRQ_W-1:0] mask_q;
    logic                   run_prev_q;
    logic                   pulse_q;

    // Bus data phase state.
    logic                   dp_wr_q;
    logic                   dp_rd_q;
    logic [7:0]             dp_addr_q;

    // Pin synchronisers and edge history.
    logic [1:0]             cap_sync_q;
    logic [1:0]             trg_sync_q;
    logic                   cap_prev_q;
    logic                   trg_prev_q;

    // Decoded events.
    logic                   in_capt;
    logic                   in_pulse;
    logic                   src_lvl;
    logic                   src_prev;
    logic                   cap_evt;
    logic                   trg_evt;
    logic                   run_rise;
    logic                   p_match;
    logic                   a_match;
    logic                   wr_ctrl;
    logic                   addr_ok;
    logic                   run_set_hw;
    logic                   run_clr_hw;

    // Returns high when the pin transition counts as active for the io setting.
    function automatic logic edge_hit(input logic [1:0] io, input logic now, input logic was);
        logic rise;
        logic fall;
        rise = now & ~was;
        fall = ~now & was;
        unique case (io)
            `PTCC_IO_RISE: edge_hit = rise;
            `PTCC_IO_FALL: edge_hit = fall;
            `PTCC_IO_BOTH: edge_hit = rise | fall;
            `PTCC_IO_NONE: edge_hit = 1'b0;
        endcase
    endfunction

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_sync_q <= 2'h0;
            trg_sync_q <= 2'h0;
            cap_prev_q <= 1'b0;
            trg_prev_q <= 1'b0;
        end else begin
            cap_sync_q <= {cap_sync_q[0], pins.capture_input_pin};   // RQ16
            trg_sync_q <= {trg_sync_q[0], pins.clock_trigger_pin};   // RQ16
            cap_prev_q <= cap_sync_q[1];
            trg_prev_q <= trg_sync_q[1];
        end
    end

    // Mode decode and event detection.
    assign in_capt  = (ctrl_q.mode_select == `PTCC_MODE_CAPT);      // RQ1
    assign in_pulse = (ctrl_q.mode_select == `PTCC_MODE_PWM) &&
                      (ctrl_q.io_function == `PTCC_IO_NONE);
    assign src_lvl  = ctrl_q.capture_source_select ? trg_sync_q[1] : cap_sync_q[1];   // RQ2
    assign src_prev = ctrl_q.capture_source_select ? trg_prev_q : cap_prev_q;         // RQ2
    // Io value 11 yields no capture event at all.
    assign cap_evt  = in_capt && edge_hit(ctrl_q.io_function, src_lvl, src_prev);     // RQ3 RQ9
    // Trigger pin active edge taken as a rising edge in single pulse operation.
    assign trg_evt  = in_pulse && trg_sync_q[1] && !trg_prev_q && !ctrl_q.counter_run;   // RQ11
    assign run_rise = ctrl_q.counter_run && !run_prev_q;                              // RQ4
    // A zero period value never matches, so the counter runs its full range.
    // The restart cycle still shows the count left from the last stop, so no match is taken then.
    assign p_match  = in_capt && ctrl_q.counter_run && !run_rise && (period_compare_value_q != `PTCC_CNT_ZERO) &&
                      (cnt_q == period_compare_value_q);                                              // RQ7 RQ8
    assign a_match  = in_pulse && ctrl_q.counter_run && !run_rise && (cnt_q == compare_a_value_q);   // RQ14
    assign run_set_hw = trg_evt;                                                      // RQ12
    assign run_clr_hw = a_match;                                                      // RQ14

    // Bus address phase decode.
    assign addr_ok = hsel && hready && htrans[1];
    assign wr_ctrl = dp_wr_q && (dp_addr_q == `PTCC_OFF_CTRL);

    // Remembers the run bit to find its rising edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= ctrl_q.counter_run;
        end
    end

    // Counter: cleared at run start, held when stopped, wrapped on period match.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= `PTCC_CNT_ZERO;
        end else if (run_rise) begin
            cnt_q <= `PTCC_CNT_ZERO;                                  // RQ4
        end else if (p_match) begin
            cnt_q <= `PTCC_CNT_ZERO;                                  // RQ7
        end else if (ctrl_q.counter_run && !a_match) begin
            cnt_q <= cnt_q + 1'b1;                                    // RQ6 RQ15
        end
    end

    // Control register: software writes, hardware sets and clears the run bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ptcc_pkg::ptcc_ctrl_t'(hwdata[`PTCC_CTRL_W-1:0]);
            end
            if (run_clr_hw) begin
                ctrl_q.counter_run <= 1'b0;                           // RQ14
            end else if (run_set_hw) begin
                ctrl_q.counter_run <= 1'b1;                           // RQ12
            end
        end
    end

    // Compare registers; a capture overrides a software write to compare A.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_a_value_q <= `PTCC_CNT_ZERO;
            period_compare_value_q <= `PTCC_CNT_ZERO;
        end else begin
            if (cap_evt) begin
                compare_a_value_q <= cnt_q;                                      // RQ5
            end else if (dp_wr_q && dp_addr_q == `PTCC_OFF_COMPARE_A_VALUE) begin
                compare_a_value_q <= hwdata[CNT_W-1:0];
            end
            if (dp_wr_q && dp_addr_q == `PTCC_OFF_PERIOD_COMPARE_VALUE) begin
                period_compare_value_q <= hwdata[CNT_W-1:0];
            end
        end
    end

    // Pulse output follows the run bit in single pulse operation only.
    // Clear select, initial level and polarity are ignored in capture.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= in_pulse && ctrl_q.counter_run && !a_match;   // RQ11 RQ10
        end
    end

    // Sticky interrupt flags; a new event wins over a write-one clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= '0;
        end else begin
            for (int i = 0; i < `PTCC_IRQ_W; i++) begin
                if (i == `PTCC_IRQ_A && (cap_evt || a_match)) begin
                    stat_q[i] <= 1'b1;                                // RQ5 RQ14 RQ17
                end else if (i == `PTCC_IRQ_P && p_match) begin
                    stat_q[i] <= 1'b1;                                // RQ7 RQ17
                end else if (dp_wr_q && dp_addr_q == `PTCC_OFF_STAT && hwdata[i]) begin
                    stat_q[i] <= 1'b0;                                // RQ17
                end
            end
        end
    end

    // Interrupt mask register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= '0;
        end else if (dp_wr_q && dp_addr_q == `PTCC_OFF_MASK) begin
            mask_q <= hwdata[`PTCC_IRQ_W-1:0];
        end
    end

    // Data phase capture of the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_wr_q   <= addr_ok && hwrite;
            dp_rd_q   <= addr_ok && !hwrite;
            dp_addr_q <= addr_ok ? haddr[7:0] : dp_addr_q;
        end
    end

    // Read data registered at the address phase; unmapped reads give zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                `PTCC_OFF_CTRL: hrdata <= {{(32-`PTCC_CTRL_W){1'b0}}, ctrl_q};
                `PTCC_OFF_COMPARE_A_VALUE: hrdata <= {{(32-CNT_W){1'b0}}, compare_a_value_q};
                `PTCC_OFF_PERIOD_COMPARE_VALUE: hrdata <= {{(32-CNT_W){1'b0}}, period_compare_value_q};
                `PTCC_OFF_CNT:  hrdata <= {{(32-CNT_W){1'b0}}, cnt_q};
                `PTCC_OFF_STAT: hrdata <= {{(32-`PTCC_IRQ_W){1'b0}}, stat_q};
                `PTCC_OFF_MASK: hrdata <= {{(32-`PTCC_IRQ_W){1'b0}}, mask_q};
                default:        hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait state slave with fixed OKAY response.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pulse_out = pulse_q;
    assign irq       = |(stat_q & mask_q);

endmodule // ptcc_timer

/* File: dv/ptcc_pin_model.sv */
// Model of the external signal source on the capture and trigger pins.
`timescale 1ns/10ps
module ptcc_pin_model (
    input  wire logic            hclk, // Timer clock.
    output ptcc_pkg::ptcc_pins_t pins  // Pin levels.
);
    // Both pins idle low until a scenario moves one.
    initial pins = '0;

    // Moves one pin just after a rising edge; sel high picks the trigger pin.
    task automatic drive(input logic sel, input logic lvl);
        @(posedge hclk);
        if (sel) pins.clock_trigger_pin <= lvl;
        else pins.capture_input_pin <= lvl;
    endtask
endmodule // ptcc_pin_model

/* File: dv/ptcc_timer_sva.sv */
// Concurrent checks on the ports of the periodic timer block.
`timescale 1ns/10ps
module ptcc_timer_chk #(
    parameter int CNT_W = 10
) (
    input wire logic                 hclk,      // Clock.
    input wire logic                 hresetn,   // Reset, active low.
    input wire logic                 hsel,      // Select.
    input wire logic [31:0]          haddr,     // Address.
    input wire logic [1:0]           htrans,    // Transfer type.
    input wire logic                 hwrite,    // Write.
    input wire logic                 hready,    // Bus ready.
    input wire logic [31:0]          hrdata,    // Read data.
    input wire logic                 hreadyout, // Slave ready.
    input wire logic                 hresp,     // Response.
    input wire ptcc_pkg::ptcc_pins_t pins,      // Pins.
    input wire logic                 pulse_out, // Pulse.
    input wire logic                 irq        // Interrupt.
);
    logic                 rd_take;
    logic                 wr_take;
    logic [3:0]           wr_age_q;
    logic [3:0]           pin_age_q;
    ptcc_pkg::ptcc_pins_t pins_q;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Transfers taken at this edge.
    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    assign wr_take = hsel & hready & htrans[1] & hwrite;

    // Cycles since the last write and the last pin change, saturating at 15.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_age_q  <= 4'hF;
            pin_age_q <= 4'hF;
            pins_q    <= '0;
        end else begin
            wr_age_q  <= wr_take ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
            pin_age_q <= (pins != pins_q) ? 4'h0 : pin_age_q + {3'h0, pin_age_q != 4'hF};
            pins_q    <= pins;
        end
    end

    ready_high_a: assert property (hreadyout)
        else $error("Slave ready dropped.");
    resp_okay_a: assert property (!hresp)
        else $error("Response was not OKAY.");
    read_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("Read data changed without a read.");
    unmapped_zero_a: assert property (rd_take && haddr[7:0] > 8'h14 |=> hrdata == 32'h0)
        else $error("Unmapped read not zero.");
    upper_zero_a: assert property (rd_take |=> (hrdata >> CNT_W) == 32'h0)
        else $error("Read data wider than the counter.");
    stat_width_a: assert property (rd_take && haddr[7:0] == 8'h10 |=> hrdata[31:2] == 30'h0)
        else $error("Status read has stray bits.");
    irq_sticky_a: assert property ($fell(irq) |-> wr_age_q <= 4'h3)
        else $error("Interrupt fell without a write.");
    pulse_cause_a: assert property ($rose(pulse_out) |-> wr_age_q <= 4'h8 ||
        (pin_age_q >= 4'h2 && pin_age_q <= 4'hA))
        else $error("Pulse started without a cause.");

    // Main scenarios reached.
    cover property ($rose(irq));
    cover property ($rose(pulse_out));
    cover property ($fell(pulse_out));
endmodule // ptcc_timer_chk

bind ptcc_timer ptcc_timer_chk #(.CNT_W(CNT_W)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .pulse_out(pulse_out), .irq(irq));

/* File: dv/tb_ptcc_timer.sv */
// Self-checking testbench for the periodic timer capture and single pulse block.
`timescale 1ns/10ps
module tb_ptcc_timer;
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic [31:0]          haddr = 32'h0;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           hsize = 3'h0;
    logic                 hwrite = 1'b0;
    logic [31:0]          hwdata = 32'h0;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    logic                 pulse_out;
    logic                 irq;
    ptcc_pkg::ptcc_pins_t pins;
    int                   mismatches = 0;
    int                   total_checks = 0;
    int                   cyc = 0;
    int                   t;
    int                   t0;
    logic [31:0]          rd;
    logic [9:0]           c0;
    logic [9:0]           expv = 10'h0;
    logic                 base = 1'b0;

    always #2.5 hclk = ~hclk;

    ptcc_timer dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pins(pins), .pulse_out(pulse_out), .irq(irq));
    ptcc_pin_model pm (.hclk(hclk), .pins(pins));

    // Counts cycles and cuts a hang short.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One single word transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Moves one pin, then checks the flag, the interrupt and compare A.
    task automatic ev(input logic s, input logic l, input logic exp);
        pm.drive(s, l);
        t = cyc;
        repeat (80) @(posedge hclk);
        bus(1'b0, 8'h10, 32'h0);
        chk("capture flag", {31'h0, rd[0]}, {31'h0, exp});
        chk("irq", {31'h0, irq}, {31'h0, exp});
        bus(1'b0, 8'h04, 32'h0);
        if (exp && !base) begin
            base = 1'b1;
            c0   = rd[9:0];
            t0   = t;
        end
        if (exp) expv = c0 + 10'(t - t0);
        chk("compare a", rd, {22'h0, expv});
        bus(1'b1, 8'h10, 32'h1);
        @(posedge hclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 24; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk("reset read", rd, 32'h0);
        end
        bus(1'b1, 8'h14, 32'h1);
        bus(1'b1, 8'h08, 32'h0);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h00, {23'h0, {3{m[1]}}, 2'b01, 2'(m), m[0], 1'b1});
            ev(!m[0], 1'b1, 1'b0);
            ev(!m[0], 1'b0, 1'b0);
            ev(m[0], 1'b1, !m[0]);
            ev(m[0], 1'b0, 1'(m == 1 || m == 2));
        end
        bus(1'b1, 8'h00, 32'h10);
        bus(1'b0, 8'h0C, 32'h0);
        expv = rd[9:0];
        repeat (5) @(posedge hclk);
        bus(1'b0, 8'h0C, 32'h0);
        chk("stopped count", rd, {22'h0, expv});
        bus(1'b1, 8'h08, 32'h14);
        bus(1'b1, 8'h00, 32'h11);
        bus(1'b1, 8'h10, 32'h3);
        repeat (30) @(posedge hclk);
        bus(1'b0, 8'h10, 32'h0);
        chk("period flag", {31'h0, rd[1]}, 32'h1);
        bus(1'b0, 8'h0C, 32'h0);
        chk("wrapped count", {31'h0, rd <= 32'h14}, 32'h1);
        bus(1'b1, 8'h00, 32'h2C);
        bus(1'b1, 8'h04, 32'h1E);
        bus(1'b1, 8'h10, 32'h3);
        pm.drive(1'b1, 1'b1);
        repeat (8) @(posedge hclk);
        chk("pulse from pin", {31'h0, pulse_out}, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        chk("run set by pin", rd, 32'h2D);
        repeat (40) @(posedge hclk);
        chk("pulse ended", {31'h0, pulse_out}, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk("run cleared", rd, 32'h2C);
        bus(1'b1, 8'h14, 32'h0);
        @(posedge hclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h14, 32'h1);
        @(posedge hclk);
        chk("match irq", {31'h0, irq}, 32'h1);
        pm.drive(1'b1, 1'b0);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h00, 32'h2D);
        repeat (6) @(posedge hclk);
        chk("pulse from run", {31'h0, pulse_out}, 32'h1);
        repeat (40) @(posedge hclk);
        chk("pulse ended", {31'h0, pulse_out}, 32'h0);
        end_sim();
    end
endmodule // tb_ptcc_timer
